//--- hdl/hmb_mailbox.v
// host/target mailbox and two-way fifo with both status registers
// assumes host and target buses are strobes on i_ref_clk; pins are asynchronous
`timescale 1ns/1ps
`include "hmb_regs.vh"

// ----------------------------------------------------------------
// fifo with valid/ready on both sides
// ----------------------------------------------------------------
module hmb_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 64,
   parameter AW    = 6
) (
   input  wire             i_clk,
   input  wire             i_reset,
   input  wire             i_clk_en,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data,
   output wire [AW:0]      o_count
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_r;
   reg  [AW-1:0]    rd_ptr_r;
   reg  [AW:0]      count_r;
   wire             push;
   wire             pop;

   // full and empty come straight from the count; a write that meets a
   // full fifo is refused here, so the caller's word is simply lost
   assign o_in_ready  = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_ptr_r];
   assign o_count     = count_r;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;

   // storage has no reset; the count alone says which words are live,
   // so stale words are never handed out
   always @(posedge i_clk) begin
      if (i_clk_en && push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   // pointers and occupancy; push and pop in one cycle leave the count as
   // it was, which keeps the level codes from flickering
   always @(posedge i_clk) begin
      if (i_reset) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else if (i_clk_en) begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------------------------------
// top: mailbox, fifo pair, host and target status/control
// ----------------------------------------------------------------
module hmb_mailbox (
   input  wire        i_ref_clk,
   input  wire        i_reset,
   input  wire        i_clk_en,
   input  wire [11:0] i_host_addr,
   input  wire [15:0] i_host_wdata,
   input  wire        i_host_wr,
   input  wire        i_host_rd,
   output wire [15:0] o_host_rdata,
   output wire        o_host_irq,
   input  wire [15:0] i_tgt_addr,
   input  wire [15:0] i_tgt_wdata,
   input  wire        i_tgt_wr,
   input  wire        i_tgt_rd,
   output wire [15:0] o_tgt_rdata,
   output wire        o_target_interrupt_one,
   output wire        o_target_reset,
   output wire        o_processor_mode_select,
   output wire        o_host_branch_input_drive,
   output wire        o_analog_interface_reset_n,
   output wire [2:0]  o_user_output,
   input  wire        i_target_external_flag,
   input  wire [1:0]  i_user_input,
   input  wire        i_card_revision_hi,
   input  wire        i_card_revision_lo
);
   // ----------------------------------------------------------------
   // state and wiring
   // ----------------------------------------------------------------
   // register state
   reg  [15:0] mbox_r;
   reg         h2t_flag_r;       // host wrote, target has not read
   reg         t2h_flag_r;       // target wrote, host has not read
   reg         fifo_tw_flag_r;
   reg  [4:0]  hctl_r;           // host bits 15..11
   reg  [3:0]  tctl_r;           // target bits 15..12
   reg  [15:0] host_rdata_r;
   reg  [15:0] tgt_rdata_r;
   reg         host_irq_r;
   reg         target_interrupt_one_r;
   // pin synchronisers
   reg  [4:0]  pin_s1_r;
   reg  [4:0]  pin_s2_r;

   // decoded accesses
   wire        h_wr_mbox;
   wire        h_rd_mbox;
   wire        h_wr_fifo;
   wire        h_rd_fifo;
   wire        h_wr_stat;
   wire        t_wr_mbox;
   wire        t_rd_mbox;
   wire        t_wr_fifo;
   wire        t_rd_fifo;
   wire        t_wr_stat;
   // fifo wires
   wire        h2t_ready;
   wire        h2t_valid;
   wire [15:0] h2t_data;
   wire [6:0]  h2t_count;
   wire        t2h_ready;
   wire        t2h_valid;
   wire [15:0] t2h_data;
   wire [6:0]  t2h_count;
   wire [15:0] hstat;
   wire [15:0] tstat;

   // ----------------------------------------------------------------
   // level coding
   // ----------------------------------------------------------------
   // four-level occupancy code from a count; shared by both status words
   function [1:0] fifo_level;
      input [6:0] cnt;
      begin
         if (cnt == 7'h00) begin
            fifo_level = `HMB_LVL_EMPTY;
         end else if (cnt == `HMB_FIFO_FULL_CNT) begin
            fifo_level = `HMB_LVL_FULL;
         end else if (cnt >= `HMB_FIFO_HALF) begin
            fifo_level = `HMB_LVL_HIGH;
         end else begin
            fifo_level = `HMB_LVL_LOW;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // one strobe qualified by one host offset
   function host_hit;
      input        strobe;
      input [11:0] addr;
      input [11:0] place;
      begin
         host_hit = strobe & (addr == place);
      end
   endfunction

   // one strobe qualified by one target port
   function tgt_hit;
      input        strobe;
      input [15:0] addr;
      input [15:0] place;
      begin
         tgt_hit = strobe & (addr == place);
      end
   endfunction

   // address decode on both sides; strobes are one cycle wide, so a
   // decoded access acts once, and not at all while i_clk_en is low
   assign h_wr_mbox = host_hit(i_host_wr, i_host_addr, `HMB_H_MBOX);
   assign h_rd_mbox = host_hit(i_host_rd, i_host_addr, `HMB_H_MBOX);
   assign h_wr_fifo = host_hit(i_host_wr, i_host_addr, `HMB_H_FIFO);
   assign h_rd_fifo = host_hit(i_host_rd, i_host_addr, `HMB_H_FIFO);
   assign h_wr_stat = host_hit(i_host_wr, i_host_addr, `HMB_H_STAT);
   assign t_wr_mbox = tgt_hit(i_tgt_wr, i_tgt_addr, `HMB_T_MBOX);
   assign t_rd_mbox = tgt_hit(i_tgt_rd, i_tgt_addr, `HMB_T_MBOX);
   assign t_wr_fifo = tgt_hit(i_tgt_wr, i_tgt_addr, `HMB_T_FIFO);
   assign t_rd_fifo = tgt_hit(i_tgt_rd, i_tgt_addr, `HMB_T_FIFO);
   assign t_wr_stat = tgt_hit(i_tgt_wr, i_tgt_addr, `HMB_T_STAT);

   // ----------------------------------------------------------------
   // fifo pair
   // ----------------------------------------------------------------
   // host to target fifo; full drops the host word
   hmb_fifo #(
      .WIDTH (16),
      .DEPTH (`HMB_FIFO_DEPTH),
      .AW    (`HMB_FIFO_AW)
   ) u_h2t (
      .i_clk       (i_ref_clk),
      .i_reset     (i_reset),
      .i_clk_en    (i_clk_en),
      .i_in_valid  (h_wr_fifo),
      .o_in_ready  (h2t_ready),
      .i_in_data   (i_host_wdata),
      .o_out_valid (h2t_valid),
      .i_out_ready (t_rd_fifo),
      .o_out_data  (h2t_data),
      .o_count     (h2t_count)
   );

   // target to host fifo
   hmb_fifo #(
      .WIDTH (16),
      .DEPTH (`HMB_FIFO_DEPTH),
      .AW    (`HMB_FIFO_AW)
   ) u_t2h (
      .i_clk       (i_ref_clk),
      .i_reset     (i_reset),
      .i_clk_en    (i_clk_en),
      .i_in_valid  (t_wr_fifo),
      .o_in_ready  (t2h_ready),
      .i_in_data   (i_tgt_wdata),
      .o_out_valid (t2h_valid),
      .i_out_ready (h_rd_fifo),
      .o_out_data  (t2h_data),
      .o_count     (t2h_count)
   );

   // ----------------------------------------------------------------
   // status words
   // ----------------------------------------------------------------
   // host status word; bit 4 echoes the branch drive the host set
   assign hstat[15:11]        = hctl_r;
   assign hstat[`HMB_H_FIFO_TW] = fifo_tw_flag_r;
   assign hstat[`HMB_H_RXLVL] = fifo_level(t2h_count);
   assign hstat[`HMB_H_REV]   = pin_s2_r[4:3];
   assign hstat[`HMB_H_XF]    = pin_s2_r[2];
   assign hstat[`HMB_H_BIO]   = hctl_r[0];
   assign hstat[`HMB_H_TXLVL] = fifo_level(h2t_count);
   assign hstat[`HMB_H_MRX]   = t2h_flag_r;
   assign hstat[`HMB_H_MTX]   = h2t_flag_r;

   // target status word; reserved bits read zero
   assign tstat[15:12]        = tctl_r;
   assign tstat[11:8]         = 4'h0;
   assign tstat[`HMB_T_UIN]   = pin_s2_r[1:0];
   assign tstat[`HMB_T_RXLVL] = fifo_level(h2t_count);
   assign tstat[`HMB_T_TXLVL] = fifo_level(t2h_count);
   assign tstat[`HMB_T_MRX]   = h2t_flag_r;
   assign tstat[`HMB_T_MTX]   = t2h_flag_r;

   // ----------------------------------------------------------------
   // board pins
   // ----------------------------------------------------------------
   // two-flop synchronisers for board pins; only the second stage is
   // read, so a pin caught mid-change never reaches a status word
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         pin_s1_r <= 5'h00;
         pin_s2_r <= 5'h00;
      end else if (i_clk_en) begin
         pin_s1_r <= {i_card_revision_hi, i_card_revision_lo,
                      i_target_external_flag, i_user_input};
         pin_s2_r <= pin_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // mailbox and event flags
   // ----------------------------------------------------------------
   // shared mailbox word, last writer wins; host wins a same-cycle tie
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         mbox_r <= 16'h0000;
      end else if (i_clk_en) begin
         if (h_wr_mbox) begin
            mbox_r <= i_host_wdata;
         end else if (t_wr_mbox) begin
            mbox_r <= i_tgt_wdata;
         end
      end
   end

   // mailbox and fifo event flags; a set beats a clear in the same cycle,
   // so a message that lands as the old one is read is never lost
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         h2t_flag_r     <= 1'b0;
         t2h_flag_r     <= 1'b0;
         fifo_tw_flag_r <= 1'b0;
      end else if (i_clk_en) begin
         if (h_wr_mbox) begin
            h2t_flag_r <= 1'b1;
         end else if (t_rd_mbox) begin
            h2t_flag_r <= 1'b0;
         end
         if (t_wr_mbox) begin
            t2h_flag_r <= 1'b1;
         end else if (h_rd_mbox) begin
            t2h_flag_r <= 1'b0;
         end
         if (t_wr_fifo) begin
            fifo_tw_flag_r <= 1'b1;
         end else if (h_rd_fifo) begin
            fifo_tw_flag_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // control bits written by each side; reset bit never touches the flags,
   // so the target can be restarted with a message still waiting
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         hctl_r <= `HMB_H_CTL_RST;
         tctl_r <= `HMB_T_CTL_RST;
      end else if (i_clk_en) begin
         if (h_wr_stat) begin
            hctl_r <= i_host_wdata[15:11];
         end
         if (t_wr_stat) begin
            tctl_r <= i_tgt_wdata[15:12];
         end
      end
   end

   // ----------------------------------------------------------------
   // read data and interrupts
   // ----------------------------------------------------------------
   // read data, interrupt pulse and host interrupt line; status reads show
   // the state from before this edge's own update
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         host_rdata_r <= 16'h0000;
         tgt_rdata_r  <= 16'h0000;
         host_irq_r   <= 1'b0;
         target_interrupt_one_r       <= 1'b0;
      end else if (i_clk_en) begin
         target_interrupt_one_r <= h_wr_mbox;
         host_irq_r <= (hctl_r[1] & t2h_flag_r)
                     | (hctl_r[2] & fifo_tw_flag_r);
         if (i_host_rd) begin
            case (i_host_addr)
               `HMB_H_MBOX: host_rdata_r <= mbox_r;
               `HMB_H_FIFO: host_rdata_r <= t2h_valid ? t2h_data : 16'h0000;
               `HMB_H_STAT: host_rdata_r <= hstat;
               default:     host_rdata_r <= 16'h0000;
            endcase
         end
         if (i_tgt_rd) begin
            case (i_tgt_addr)
               `HMB_T_MBOX: tgt_rdata_r <= mbox_r;
               `HMB_T_FIFO: tgt_rdata_r <= h2t_valid ? h2t_data : 16'h0000;
               `HMB_T_STAT: tgt_rdata_r <= tstat;
               default:     tgt_rdata_r <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // outputs, all from flops
   assign o_host_rdata               = host_rdata_r;
   assign o_tgt_rdata                = tgt_rdata_r;
   assign o_host_irq                 = host_irq_r;
   assign o_target_interrupt_one     = target_interrupt_one_r;
   assign o_target_reset             = hctl_r[4];
   assign o_processor_mode_select    = hctl_r[3];
   assign o_host_branch_input_drive  = hctl_r[0];
   assign o_analog_interface_reset_n = tctl_r[3];
   assign o_user_output              = tctl_r[2:0];
endmodule

//--- hdl/hmb_regs.vh
// constants for the host/target mailbox and fifo block
// assumes one 40 MHz clock; the host and target buses run on that clock
`ifndef HMB_REGS_VH
`define HMB_REGS_VH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define HMB_T_MBOX        16'h0010
`define HMB_T_FIFO        16'h0012
`define HMB_T_STAT        16'h0014
`define HMB_H_MBOX        12'h800
`define HMB_H_FIFO        12'h804
`define HMB_H_STAT        12'h808

// ----------------------------------------------------------------
// host status/control fields
// ----------------------------------------------------------------
`define HMB_H_TRESET      15
`define HMB_H_MODE        14
`define HMB_H_FIFO_IE     13
`define HMB_H_MBOX_IE     12
`define HMB_H_BIO_DRV     11
`define HMB_H_FIFO_TW     10
`define HMB_H_RXLVL       9:8
`define HMB_H_REV         7:6
`define HMB_H_XF          5
`define HMB_H_BIO         4
`define HMB_H_TXLVL       3:2
`define HMB_H_MRX         1
`define HMB_H_MTX         0
`define HMB_H_CTL_RST     5'h00

// ----------------------------------------------------------------
// target status/control fields
// ----------------------------------------------------------------
`define HMB_T_AIC         15
`define HMB_T_UOUT        14:12
`define HMB_T_UIN         7:6
`define HMB_T_RXLVL       5:4
`define HMB_T_TXLVL       3:2
`define HMB_T_MRX         1
`define HMB_T_MTX         0
`define HMB_T_CTL_RST     4'h0

// ----------------------------------------------------------------
// fifo geometry and level codes
// ----------------------------------------------------------------
`define HMB_FIFO_DEPTH    64
`define HMB_FIFO_AW       6
`define HMB_FIFO_HALF     7'h20
`define HMB_FIFO_FULL_CNT 7'h40
`define HMB_LVL_EMPTY     2'h0
`define HMB_LVL_LOW       2'h1
`define HMB_LVL_HIGH      2'h2
`define HMB_LVL_FULL      2'h3

`endif

//--- tb/hmb_bus_model.sv
// strobe-driven bus master standing for the host or target processor
// assumes the block answers one edge after the strobe, without any stall
`timescale 1ns/1ps

// ----------------------------------------------------------------
// bus master with one-cycle strobes
// ----------------------------------------------------------------
module hmb_bus_model #(
   parameter AW = 12
) (
   input  wire          i_clk,
   input  wire [15:0]   i_rdata,
   output reg  [AW-1:0] o_addr,
   output reg  [15:0]   o_wdata,
   output reg           o_wr,
   output reg           o_rd
);
   // idle bus at time zero
   initial begin
      o_addr = '0;
      o_wdata = '0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // one access; released lines show the inverse so stale values never match
   task xfer(input w, input [AW-1:0] a, input [15:0] d, output [15:0] q);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = w;
      o_rd = !w;
      @(negedge i_clk);
      q = i_rdata;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
endmodule

//--- tb/hmb_mailbox_props.sv
// concurrent checks on the ports of the mailbox top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "hmb_regs.vh"

// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module hmb_mailbox_props (
   input wire        i_ref_clk,
   input wire        i_reset,
   input wire        i_clk_en,
   input wire [11:0] i_host_addr,
   input wire [15:0] i_host_wdata,
   input wire        i_host_wr,
   input wire [15:0] i_tgt_addr,
   input wire [15:0] i_tgt_wdata,
   input wire        i_tgt_wr,
   input wire        o_target_interrupt_one,
   input wire        o_target_reset,
   input wire        o_processor_mode_select,
   input wire        o_host_branch_input_drive,
   input wire        o_analog_interface_reset_n,
   input wire [2:0]  o_user_output
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // decoded writes
   wire hm = i_clk_en && i_host_wr && (i_host_addr == `HMB_H_MBOX);
   wire hs = i_clk_en && i_host_wr && (i_host_addr == `HMB_H_STAT);
   wire ts = i_clk_en && i_tgt_wr && (i_tgt_addr == `HMB_T_STAT);

   property p_tint_set; hm |=> o_target_interrupt_one; endproperty
   a_tint_set: assert property (p_tint_set) else $error("no target interrupt");
   property p_tint_src; o_target_interrupt_one |-> $past(hm); endproperty
   a_tint_src: assert property (p_tint_src) else $error("stray target interrupt");
   property p_trst; hs |=> o_target_reset == $past(i_host_wdata[15]); endproperty
   a_trst: assert property (p_trst) else $error("target reset wrong");
   property p_mode; hs |=> o_processor_mode_select == $past(i_host_wdata[14]); endproperty
   a_mode: assert property (p_mode) else $error("mode select wrong");
   property p_bio; hs |=> o_host_branch_input_drive == $past(i_host_wdata[11]); endproperty
   a_bio: assert property (p_bio) else $error("branch drive wrong");
   property p_hold;
      !hs |=> $stable({o_target_reset, o_processor_mode_select, o_host_branch_input_drive});
   endproperty
   a_hold: assert property (p_hold) else $error("host controls moved");
   property p_aic; ts |=> o_analog_interface_reset_n == $past(i_tgt_wdata[15]); endproperty
   a_aic: assert property (p_aic) else $error("analog reset wrong");
   property p_uout; ts |=> o_user_output == $past(i_tgt_wdata[14:12]); endproperty
   a_uout: assert property (p_uout) else $error("user outputs wrong");
endmodule

bind hmb_mailbox hmb_mailbox_props hmb_mailbox_props_inst (.i_ref_clk, .i_reset, .i_clk_en,
   .i_host_addr, .i_host_wdata, .i_host_wr, .i_tgt_addr, .i_tgt_wdata, .i_tgt_wr,
   .o_target_interrupt_one, .o_target_reset, .o_processor_mode_select,
   .o_host_branch_input_drive, .o_analog_interface_reset_n, .o_user_output);

//--- tb/hmb_mailbox_tb.sv
// self-checking bench for the mailbox and fifo block
// assumes host and target buses are driven by two bus models on one clock
`timescale 1ns/1ps
`include "hmb_regs.vh"

module hmb_mailbox_tb;
   reg         clk = 0, rst = 1, xf = 0, rh = 0, rl = 0, ce = 1;
   reg  [1:0]  uin = 0;
   reg  [15:0] q;
   integer     err_total = 0, checked = 0, i;
   wire [11:0] haddr;
   wire [15:0] hwd, hrd, taddr, twd, trd;
   wire        hwr, hrd_s, twr, trd_s, irq, tint, trst, mode, bio, aicn;
   wire [2:0]  uout;

   // ----------------------------------------------------------------
   // clock, parts
   // ----------------------------------------------------------------
   initial forever #12.5 clk = ~clk;
   hmb_bus_model #(.AW(12)) host_bus (.i_clk(clk), .i_rdata(hrd), .o_addr(haddr),
      .o_wdata(hwd), .o_wr(hwr), .o_rd(hrd_s));
   hmb_bus_model #(.AW(16)) tgt_bus (.i_clk(clk), .i_rdata(trd), .o_addr(taddr),
      .o_wdata(twd), .o_wr(twr), .o_rd(trd_s));
   hmb_mailbox hmb_mailbox_inst (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(ce),
      .i_host_addr(haddr), .i_host_wdata(hwd), .i_host_wr(hwr), .i_host_rd(hrd_s),
      .o_host_rdata(hrd), .o_host_irq(irq), .i_tgt_addr(taddr), .i_tgt_wdata(twd),
      .i_tgt_wr(twr), .i_tgt_rd(trd_s), .o_tgt_rdata(trd), .o_target_interrupt_one(tint),
      .o_target_reset(trst), .o_processor_mode_select(mode), .o_host_branch_input_drive(bio),
      .o_analog_interface_reset_n(aicn), .o_user_output(uout), .i_target_external_flag(xf),
      .i_user_input(uin), .i_card_revision_hi(rh), .i_card_revision_lo(rl));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task chk(input [15:0] s, input [15:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("Error at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task hw(input [11:0] a, input [15:0] d); host_bus.xfer(1, a, d, q); endtask
   task hc(input [11:0] a, input [15:0] e); host_bus.xfer(0, a, 0, q); chk(q, e); endtask
   task tw(input [15:0] a, input [15:0] d); tgt_bus.xfer(1, a, d, q); endtask
   task tc(input [15:0] a, input [15:0] e); tgt_bus.xfer(0, a, 0, q); chk(q, e); endtask
   task irq_is(input e); repeat (2) @(negedge clk); chk(irq, e); endtask
   function [1:0] lv(input integer n);
      lv = (n == 0) ? 2'h0 : (n < 32) ? 2'h1 : (n < 64) ? 2'h2 : 2'h3;
   endfunction
   task test_done;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // control bits act on the target but leave the mailbox flags alone
   task t_ctrl;
      hw(`HMB_H_MBOX, 16'hc3c3);
      chk(tint, 1);
      hc(`HMB_H_STAT, 16'h0001);
      chk(tint, 0);
      tc(`HMB_T_STAT, 16'h0002);
      hw(`HMB_H_STAT, 16'hc800);
      chk(trst, 1);
      chk(mode, 1);
      chk(bio, 1);
      hc(`HMB_H_STAT, 16'hc811);
      hw(`HMB_H_STAT, 16'h0000);
      tc(`HMB_T_MBOX, 16'hc3c3);
      hc(`HMB_H_STAT, 16'h0000);
      tc(`HMB_T_STAT, 16'h0000);
   endtask
   // host to target fifo filled past full, then drained past empty
   task t_fifo_h2t;
      for (i = 1; i <= 65; i++) begin
         hw(`HMB_H_FIFO, 16'h1000 + i);
         hc(`HMB_H_STAT, {12'h000, lv(i > 64 ? 64 : i), 2'b00});
      end
      tc(`HMB_T_STAT, 16'h0030);
      for (i = 1; i <= 64; i++) tc(`HMB_T_FIFO, 16'h1000 + i);
      tc(`HMB_T_FIFO, 16'h0000);
      tc(`HMB_T_STAT, 16'h0000);
   endtask
   // target to host traffic with both host interrupt enables
   task t_t2h;
      hw(`HMB_H_STAT, 16'h2000);
      for (i = 1; i <= 33; i++) tw(`HMB_T_FIFO, i);
      hc(`HMB_H_STAT, 16'h2600);
      tc(`HMB_T_STAT, 16'h0008);
      irq_is(1);
      hc(`HMB_H_FIFO, 16'h0001);
      hc(`HMB_H_STAT, 16'h2200);
      irq_is(0);
      for (i = 2; i <= 33; i++) hc(`HMB_H_FIFO, i);
      hc(`HMB_H_STAT, 16'h2000);
      // fifo now drained, so the mailbox handshake starts clean
      hw(`HMB_H_STAT, 16'h1000);
      tw(`HMB_T_MBOX, 16'h5a5a);
      hc(`HMB_H_STAT, 16'h1002);
      tc(`HMB_T_STAT, 16'h0001);
      irq_is(1);
      hc(`HMB_H_MBOX, 16'h5a5a);
      tc(`HMB_T_STAT, 16'h0000);
      irq_is(0);
      hw(`HMB_H_STAT, 16'h0000);
   endtask
   // pins, read-only and reserved bits, unmapped places
   task t_pins;
      xf = 1;
      rh = 1;
      uin = 2'b10;
      repeat (4) @(negedge clk);
      hw(`HMB_H_STAT, 16'h07ff);
      hc(`HMB_H_STAT, 16'h00a0);
      tw(`HMB_T_STAT, 16'hffff);
      tc(`HMB_T_STAT, 16'hf080);
      chk(aicn, 1);
      tw(`HMB_T_STAT, 16'h2000);
      chk(aicn, 0);
      chk(uout, 3'b010);
      hc(12'h80c, 16'h0000);
      tc(16'h0016, 16'h0000);
   endtask
   // clock enable low freezes the controls; reset in mid-run restores power-up state
   task t_rerun;
      hw(`HMB_H_STAT, 16'hc000);
      ce = 0;
      hw(`HMB_H_STAT, 16'h0000);
      ce = 1;
      chk(mode, 1);
      chk(trst, 1);
      @(negedge clk) rst = 1;
      repeat (3) @(negedge clk);
      rst = 0;
      repeat (4) @(negedge clk);
      chk(mode, 0);
      hc(`HMB_H_STAT, 16'h00a0);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      chk(mode, 0);
      hc(`HMB_H_STAT, 16'h0000);
      tc(`HMB_T_STAT, 16'h0000);
      t_ctrl;
      t_fifo_h2t;
      t_t2h;
      t_pins;
      t_rerun;
      test_done;
   end
   initial begin
      #200000;
      err_total++;
      test_done;
   end
endmodule
